// ===== verilog/ochs_pkg.sv
// Package: constants and types for the over-current hiccup sequencer
package ochs_pkg;
   localparam int unsigned         SS_CNT_W        = 11;
   localparam logic [10:0]         SS_CNT_LAST     = 11'h7ff;
   localparam logic [10:0]         SS_CNT_RST      = 11'h000;
   // A trip on this retry latches off: seven wait-and-retry cycles at most
   localparam logic [3:0]          OC_ATTEMPT_MAX  = 4'h7;
   localparam logic [3:0]          OC_ATTEMPT_RST  = 4'h0;
   localparam logic [3:0]          REG_CTRL        = 4'h0;
   localparam logic [3:0]          REG_STATUS      = 4'h4;
   localparam logic [3:0]          REG_INT_STAT    = 4'h8;
   localparam logic [3:0]          REG_INT_MASK    = 4'hc;
   localparam int unsigned         CTRL_SW_EN_BIT  = 0;
   localparam logic                CTRL_SW_EN_RST  = 1'h1;
   localparam int unsigned         STAT_STATE_LSB  = 0;
   localparam int unsigned         STAT_RETRY_LSB  = 4;
   localparam int unsigned         STAT_PG_BIT     = 8;
   localparam int unsigned         STAT_PG_PIN_BIT = 9;
   localparam int unsigned         STAT_VID_BIT    = 10;
   localparam int unsigned         INT_W           = 3;
   localparam int unsigned         INT_OC_TRIP     = 0;
   localparam int unsigned         INT_LATCHED     = 1;
   localparam int unsigned         INT_SS_DONE     = 2;
   localparam logic [2:0]          INT_MASK_RST    = 3'h0;
   localparam logic [2:0]          SYNC_RST        = 3'h0;

   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_SS    = 3'b001,
      ST_RUN   = 3'b010,
      ST_WAIT  = 3'b011,
      ST_LATCH = 3'b100
   } ochs_state_t;

   function automatic logic ochs_cnt_last(input logic [10:0] cnt);
      return cnt == SS_CNT_LAST;
   endfunction
endpackage

// ===== verilog/ochs_sync.sv
// Three-stage pin synchroniser; output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ochs_sync
   import ochs_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_reset_n,
   input  wire logic i_pin,
   output var  logic o_level
);
   logic [2:0] stage_ff;
   logic       level_ff;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stage_ff <= SYNC_RST;
      end else begin
         stage_ff <= {stage_ff[1:0], i_pin};
      end
   end

   // Stage zero is read only by stage one
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         level_ff <= 1'b0;
      end else if (stage_ff[1] == stage_ff[2]) begin
         level_ff <= stage_ff[2];
      end
   end

   assign o_level = level_ff;
endmodule // ochs_sync
`default_nettype wire

// ===== verilog/ochs_seq.sv
// Over-current hiccup sequencer with Wishbone register slave and interrupt
`timescale 1ns/1ps
`default_nettype none
module ochs_seq
   import ochs_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output var  logic [31:0] o_wb_dat,
   output var  logic        o_wb_ack,
   input  wire logic        i_overcurrent_flag,
   input  wire logic        i_uv_ok,
   input  wire logic        i_enable_ok,
   input  wire logic        i_por_ok,
   input  wire logic        i_output_voltage_code_busy,
   input  wire logic        i_phase_clk,
   input  wire logic        i_power_good_flag,
   output var  logic        o_power_good_flag,
   output var  logic        o_power_good_flag_oe_n,
   output var  logic        o_pwm_hiz,
   output var  logic        o_soft_start,
   output var  logic        o_irq
);
   import ochs_pkg::*;

   logic              oc_s;
   logic              uv_s;
   logic              en_s;
   logic              por_s;
   logic              vid_s;
   logic              phase_s;
   logic              pg_pin_s;
   logic              phase_prev_ff;
   logic              phase_pulse;
   logic              oc_hit;
   logic              go_off;
   logic              start_ok;
   ochs_state_t       state_ff;
   ochs_state_t       nxt_state;
   logic [10:0]       cnt_ff;
   logic [3:0]        retry_ff;
   logic              pg_ff;
   logic              hiz_ff;
   logic              sw_en_ff;
   logic [INT_W-1:0]  int_stat_ff;
   logic [INT_W-1:0]  int_mask_ff;
   logic [INT_W-1:0]  int_evt;
   logic              irq_ff;
   logic              ack_ff;
   logic [31:0]       rdat_ff;
   logic              wb_req;
   logic              wb_wr;
   logic              wb_rd;

   ochs_sync u_sync_oc (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_pin     (i_overcurrent_flag),
      .o_level   (oc_s)
   );
   ochs_sync u_sync_uv (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_pin     (i_uv_ok),
      .o_level   (uv_s)
   );
   ochs_sync u_sync_en (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_pin     (i_enable_ok),
      .o_level   (en_s)
   );
   ochs_sync u_sync_por (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_pin     (i_por_ok),
      .o_level   (por_s)
   );
   ochs_sync u_sync_vid (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_pin     (i_output_voltage_code_busy),
      .o_level   (vid_s)
   );
   ochs_sync u_sync_phase (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_pin     (i_phase_clk),
      .o_level   (phase_s)
   );
   ochs_sync u_sync_pg (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_pin     (i_power_good_flag),
      .o_level   (pg_pin_s)
   );

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_prev_ff <= 1'b0;
      end else begin
         phase_prev_ff <= phase_s;
      end
   end

   // One pulse per rising phase-clock edge
   assign phase_pulse = phase_s & ~phase_prev_ff;
   // Blanking hides charge currents during a code change
   assign oc_hit      = oc_s & ~vid_s;
   assign go_off      = ~en_s | ~por_s;
   assign start_ok    = en_s & por_s & sw_en_ff;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_OFF: begin
            if (start_ok) begin
               nxt_state = ST_SS;
            end
         end
         ST_SS: begin
            if (!sw_en_ff) begin
               nxt_state = ST_OFF;
            end else if (oc_hit) begin
               if (retry_ff == OC_ATTEMPT_MAX) begin
                  nxt_state = ST_LATCH;
               end else begin
                  nxt_state = ST_WAIT;
               end
            end else if (phase_pulse && ochs_cnt_last(cnt_ff)) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!sw_en_ff) begin
               nxt_state = ST_OFF;
            end else if (oc_hit) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!sw_en_ff) begin
               nxt_state = ST_OFF;
            end else if (phase_pulse && ochs_cnt_last(cnt_ff)) begin
               nxt_state = ST_SS;
            end
         end
         ST_LATCH: begin
            nxt_state = ST_LATCH;
         end
         default: begin
            nxt_state = ST_OFF;
         end
      endcase
      if (go_off) begin
         nxt_state = ST_OFF;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff <= ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // One counter times both the wait and the ramp; it restarts on every state change
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_ff <= SS_CNT_RST;
      end else if (nxt_state != state_ff) begin
         cnt_ff <= SS_CNT_RST;
      end else if (phase_pulse) begin
         cnt_ff <= cnt_ff + 11'h001;
      end
   end

   // Attempt counter: counts returns from wait to soft-start since the last good run or off
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         retry_ff <= OC_ATTEMPT_RST;
      end else if (nxt_state == ST_OFF || nxt_state == ST_RUN) begin
         retry_ff <= OC_ATTEMPT_RST;
      end else if (state_ff == ST_WAIT && nxt_state == ST_SS) begin
         retry_ff <= retry_ff + 4'h1;
      end
   end

   // Outputs follow the next state so a trip reaches the pins one edge after it is seen
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hiz_ff <= 1'b1;
      end else begin
         hiz_ff <= !(nxt_state == ST_SS || nxt_state == ST_RUN);
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pg_ff <= 1'b0;
      end else begin
         pg_ff <= (nxt_state == ST_SS || nxt_state == ST_RUN) && uv_s;
      end
   end

   assign o_pwm_hiz              = hiz_ff;
   assign o_soft_start           = (state_ff == ST_SS);
   assign o_power_good_flag      = 1'b0;
   // Open drain: the pin is pulled low whenever power is not good
   assign o_power_good_flag_oe_n = pg_ff;

   assign int_evt[INT_OC_TRIP] = nxt_state == ST_WAIT && state_ff != ST_WAIT;
   assign int_evt[INT_LATCHED] = nxt_state == ST_LATCH && state_ff != ST_LATCH;
   assign int_evt[INT_SS_DONE] = nxt_state == ST_RUN && state_ff == ST_SS;

   assign wb_req = i_wb_cyc & i_wb_stb & ~ack_ff;
   assign wb_wr  = wb_req & i_wb_we;
   assign wb_rd  = wb_req & ~i_wb_we;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= wb_req;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sw_en_ff <= CTRL_SW_EN_RST;
      end else if (wb_wr && i_wb_adr == REG_CTRL && i_wb_sel[0]) begin
         sw_en_ff <= i_wb_dat[CTRL_SW_EN_BIT];
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         int_mask_ff <= INT_MASK_RST;
      end else if (wb_wr && i_wb_adr == REG_INT_MASK && i_wb_sel[0]) begin
         int_mask_ff <= i_wb_dat[INT_W-1:0];
      end
   end

   // Read clears; an event in the same cycle survives the clear
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         int_stat_ff <= '0;
      end else if (wb_rd && i_wb_adr == REG_INT_STAT) begin
         int_stat_ff <= int_evt;
      end else begin
         int_stat_ff <= int_stat_ff | int_evt;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(int_stat_ff & int_mask_ff);
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdat_ff <= 32'h0000_0000;
      end else if (wb_rd) begin
         rdat_ff <= 32'h0000_0000;
         unique case (i_wb_adr)
            REG_CTRL: begin
               rdat_ff[CTRL_SW_EN_BIT] <= sw_en_ff;
            end
            REG_STATUS: begin
               rdat_ff[STAT_STATE_LSB +: 3] <= state_ff;
               rdat_ff[STAT_RETRY_LSB +: 4] <= retry_ff;
               rdat_ff[STAT_PG_BIT]         <= pg_ff;
               rdat_ff[STAT_PG_PIN_BIT]     <= pg_pin_s;
               rdat_ff[STAT_VID_BIT]        <= vid_s;
            end
            REG_INT_STAT: begin
               rdat_ff[INT_W-1:0] <= int_stat_ff;
            end
            REG_INT_MASK: begin
               rdat_ff[INT_W-1:0] <= int_mask_ff;
            end
            default: begin
               rdat_ff <= 32'h0000_0000;
            end
         endcase
      end
   end

   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;
   assign o_irq    = irq_ff;

   logic run_ok;
   assign run_ok = en_s & por_s & sw_en_ff;

   AST_OC_RUN: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_RUN && oc_hit && run_ok |=> state_ff == ST_WAIT && o_pwm_hiz)
      else $error("trip while running did not shut down");
   AST_WAIT_HIZ: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_WAIT |-> o_pwm_hiz && o_power_good_flag_oe_n == 1'b0)
      else $error("pwm or power good wrong while waiting");
   AST_WAIT_END: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_WAIT && phase_pulse && cnt_ff == 11'h7ff && run_ok
      |=> state_ff == ST_SS)
      else $error("wait did not end after 2048 phase clocks");
   AST_SS_TRIP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_SS && oc_hit && run_ok && retry_ff != OC_ATTEMPT_MAX
      |=> state_ff == ST_WAIT ##1 o_pwm_hiz)
      else $error("soft-start trip did not start a new wait");
   AST_LATCH_IN: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_SS && oc_hit && en_s && por_s && sw_en_ff && retry_ff == OC_ATTEMPT_MAX
      |=> state_ff == ST_LATCH)
      else $error("eighth trip did not latch off");
   AST_LATCH_HOLD: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_LATCH && en_s && por_s |=> state_ff == ST_LATCH && o_pwm_hiz)
      else $error("latched off state left without enable drop");
   AST_SS_DONE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_SS && phase_pulse && cnt_ff == 11'h7ff && !oc_hit && run_ok
      |=> state_ff == ST_RUN && retry_ff == 4'h0)
      else $error("clean soft-start did not resume run");
   AST_BLANK: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_RUN && vid_s |=> state_ff != ST_WAIT)
      else $error("trip taken during code transition");
   AST_CNT_STEP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_SS && phase_pulse && nxt_state == ST_SS
      |=> cnt_ff == $past(cnt_ff) + 11'h001)
      else $error("soft-start counter did not advance on phase pulse");
   AST_PG_UV: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      state_ff == ST_SS && !uv_s && nxt_state == ST_SS |=> o_power_good_flag_oe_n == 1'b0)
      else $error("power good released before under-voltage cleared");
   AST_RETRY_CAP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      retry_ff <= OC_ATTEMPT_MAX)
      else $error("attempt count beyond limit");
endmodule // ochs_seq
`default_nettype wire

// ===== tb/ochs_far_side.sv
// Model of the gate drivers and power monitor facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module ochs_far_side (
   input  wire logic i_mclk,
   input  wire logic i_pwm_hiz,
   input  wire logic i_pg_oe_n,
   input  wire logic i_pg_data,
   input  wire logic i_load_fault,
   input  wire logic i_out_rising,
   output var  logic o_phase_clk,
   output var  logic o_overcurrent_flag,
   output var  logic o_uv_ok,
   output var  logic o_pg_wire
);
   logic [1:0] div_ff = 2'h0;
   // Fastest phase clock the pin synchroniser still resolves, to keep 2048 counts short
   always @(posedge i_mclk) begin
      div_ff <= div_ff + 2'h1;
   end
   assign o_phase_clk = div_ff[1];
   // Current and output voltage exist only while the drivers switch
   assign o_overcurrent_flag = i_load_fault & ~i_pwm_hiz;
   assign o_uv_ok = i_out_rising & ~i_pwm_hiz;
   // Open-drain line with a pull-up
   assign o_pg_wire = i_pg_oe_n ? 1'b1 : i_pg_data;
endmodule // ochs_far_side
`default_nettype wire

// ===== tb/tb_ochs_seq.sv
// Self-checking bench for the over-current hiccup sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_ochs_seq;
   import ochs_pkg::*;
   logic        i_mclk, i_reset_n, cyc, stb, we, en_ok, por_ok, busy, fault, rising, ok;
   logic [3:0]  adr;
   logic [31:0] wdat, rd, lfsr;
   wire  logic [31:0] rdat;
   wire  logic  ack, oc, uv, ph, pg_d, pg_oe_n, hiz, ss, irq, pg_wire;
   int          n_fail, checks, n_pulse, p0, n_ss;

   ochs_seq ochs_seq_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_overcurrent_flag(oc), .i_uv_ok(uv),
      .i_enable_ok(en_ok), .i_por_ok(por_ok), .i_output_voltage_code_busy(busy),
      .i_phase_clk(ph), .i_power_good_flag(pg_wire), .o_power_good_flag(pg_d),
      .o_power_good_flag_oe_n(pg_oe_n), .o_pwm_hiz(hiz), .o_soft_start(ss), .o_irq(irq));
   ochs_far_side ochs_far_side_i (.i_mclk(i_mclk), .i_pwm_hiz(hiz), .i_pg_oe_n(pg_oe_n),
      .i_pg_data(pg_d), .i_load_fault(fault), .i_out_rising(rising), .o_phase_clk(ph),
      .o_overcurrent_flag(oc), .o_uv_ok(uv), .o_pg_wire(pg_wire));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_stat(input logic [2:0] st, input logic [3:0] n);
      return {24'h0, n, 1'b0, st};
   endfunction
   function automatic logic pick(input int sel);
      return sel == 0 ? ss : (sel == 1 ? hiz : pg_wire);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      checks++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %0d", $time, what, got);
      end
   endtask
   // Single classic cycle; the request is held until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      chk({31'h0, ack}, 32'h1, "bus ack");
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic wait_for(input int sel, input logic v, input int lim, input bit must,
                           output logic got);
      int n;
      n = 0;
      while (pick(sel) !== v && n < lim) begin
         @(posedge i_mclk);
         n++;
      end
      got = (pick(sel) === v);
      if (must) chk({31'h0, got}, 32'h1, "signal wait");
   endtask
   task automatic give_verdict();
      $display("Comparisons: %0d, mismatches: %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge ph) begin
      n_pulse++;
   end
   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end
   // Longest legal run is about 90700 cycles, mostly 2048-pulse waits
   initial begin
      repeat (98000) @(posedge i_mclk);
      n_fail++;
      give_verdict();
   end
   initial begin
      {cyc, stb, we, busy, fault, rising, en_ok} = 7'h0;
      por_ok = 1'b1;
      adr = 4'h0;
      wdat = 32'h0;
      lfsr = 32'h9c1e;
      i_reset_n = 1'b0;
      repeat (8) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      chk({31'h0, hiz}, 32'h1, "hiz in reset");
      wb(1'b0, REG_CTRL, 32'h0, rd);
      chk(rd & 32'h1, 32'h1, "ctrl reset");
      wb(1'b0, REG_INT_MASK, 32'h0, rd);
      chk(rd & 32'h7, 32'h0, "mask reset");
      wb(1'b0, 4'h2, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      lfsr = lfsr_next(lfsr);
      wb(1'b1, REG_INT_MASK, lfsr, rd);
      wb(1'b0, REG_INT_MASK, 32'h0, rd);
      chk(rd & 32'h7, lfsr & 32'h7, "mask readback");
      wb(1'b1, REG_INT_MASK, 32'h1, rd);
      // Clean first soft-start, output voltage held low at first
      en_ok <= 1'b1;
      wait_for(0, 1'b1, 20, 1, ok);
      p0 = n_pulse;
      repeat (100) @(posedge i_mclk);
      chk({31'h0, pg_wire}, 32'h0, "pg before uv");
      rising <= 1'b1;
      wait_for(2, 1'b1, 12, 1, ok);
      chk({31'h0, ss}, 32'h1, "pg in soft-start");
      wait_for(0, 1'b0, 8400, 1, ok);
      chk_rng(n_pulse - p0, 2047, 2049, "soft-start pulses");
      chk({30'h0, hiz, irq}, 32'h0, "run, done event masked");
      wb(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd & 32'h7f7, exp_stat(3'h2, 4'h0) | 32'h300, "status run");
      wb(1'b0, REG_INT_STAT, 32'h0, rd);
      chk(rd & 32'h7, 32'h4, "done event");
      wb(1'b0, REG_INT_STAT, 32'h0, rd);
      chk(rd & 32'h7, 32'h0, "read clears");
      // Trip held off by a code transition, then taken at once
      busy <= 1'b1;
      fault <= 1'b1;
      repeat (40) @(posedge i_mclk);
      chk({31'h0, hiz}, 32'h0, "blanked");
      wb(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd & 32'h7f7, exp_stat(3'h2, 4'h0) | 32'h700, "blanked status");
      lfsr = lfsr_next(lfsr);
      repeat (lfsr[3:0]) @(posedge i_mclk);
      busy <= 1'b0;
      wait_for(1, 1'b1, 12, 1, ok);
      p0 = n_pulse;
      wait_for(2, 1'b0, 3, 1, ok);
      repeat (2) @(posedge i_mclk);
      chk({31'h0, irq}, 32'h1, "irq raised");
      fault <= 1'b0;
      wb(1'b0, REG_INT_STAT, 32'h0, rd);
      chk(rd & 32'h1, 32'h1, "trip event");
      chk({31'h0, irq}, 32'h0, "irq cleared");
      wait_for(0, 1'b1, 8400, 1, ok);
      chk_rng(n_pulse - p0, 2047, 2049, "wait pulses");
      wb(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd & 32'hf7, exp_stat(3'h1, 4'h1), "retry count");
      wait_for(0, 1'b0, 8400, 1, ok);
      wb(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd & 32'hf7, exp_stat(3'h2, 4'h0), "retry cleared");
      // Persistent fault: hiccup until latched off
      fault <= 1'b1;
      n_ss = 0;
      ok = 1'b1;
      while (ok && n_ss < 12) begin
         wait_for(1, 1'b0, 10, 1, ok);
         wait_for(1, 1'b1, 12, 1, ok);
         wait_for(0, 1'b1, 8400, 0, ok);
         n_ss += ok;
      end
      chk(n_ss, 7, "soft-start attempts");
      repeat (200) @(posedge i_mclk);
      chk({30'h0, hiz, pg_wire}, 32'h2, "latched outputs");
      wb(1'b1, REG_CTRL, 32'h0, rd);
      wb(1'b1, REG_CTRL, 32'h1, rd);
      wb(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd & 32'h7, 32'h4, "still latched");
      fault <= 1'b0;
      en_ok <= 1'b0;
      repeat (20) @(posedge i_mclk);
      wb(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd & 32'hf7, exp_stat(3'h0, 4'h0), "off after enable drop");
      en_ok <= 1'b1;
      wait_for(0, 1'b1, 20, 1, ok);
      // Software disable takes the ramp back to off
      wb(1'b1, REG_CTRL, 32'h0, rd);
      wb(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd & 32'hf7, exp_stat(3'h0, 4'h0), "software disable");
      chk({31'h0, hiz}, 32'h1, "hiz when disabled");
      give_verdict();
   end
endmodule // tb_ochs_seq
`default_nettype wire
